// File: hdl/dils_regs.svh
// constants for the display inhibit / load sequencer
// assumes: included by bare name from every design file that needs a figure
`ifndef DILS_REGS_SVH
`define DILS_REGS_SVH

// frame layout: selector first, then payload, msb first
`define DILS_SEL_W 3
`define DILS_PAY_W 129
`define DILS_FRAME_W 132
`define DILS_CNT_W 8
`define DILS_FIFO_DEPTH 4
`define DILS_FIFO_AW 2
`define DILS_FRAME_BITS 8'h84
`define DILS_LAST_BIT 8'h83

// selector codes
`define DILS_SEL_PART0 3'h0
`define DILS_SEL_PART1 3'h1
`define DILS_SEL_PART2 3'h2
`define DILS_SEL_PART3 3'h3
`define DILS_SEL_CTRL 3'h4

// control payload fields
`define DILS_CTRL_DUTY_BIT 0
`define DILS_CTRL_OSC_BIT 1
`define DILS_SEG_TOP 128

// display rows and scan
`define DILS_ROWS 4
`define DILS_ROW_W 2
`define DILS_ROW_LAST_THIRD 2'h2
`define DILS_ROW_LAST_QUARTER 2'h3
`define DILS_RC_DIV_W 4
`define DILS_RC_DIV_LAST 4'hf

// host link timing, in I_CLK cycles
`define DILS_HALF_W 2
`define DILS_HALF_LAST 2'h1
`define DILS_WAIT_W 4
`define DILS_HOLD_LAST 4'h7
`define DILS_GAP_LAST 4'h7

// whole-transfer time limit
`define DILS_CLK_PERIOD_NS 50
`define DILS_TRANSFER_MAX_NS 30000000
`define DILS_SLOW_W 20

`endif

// File: hdl/dils_pkg.sv
// types shared by both ends of the display load link
// assumes: dils_regs.svh sits in the include path
`include "dils_regs.svh"

package dils_pkg;

   typedef logic [`DILS_FRAME_W-1:0] frame_t;
   typedef logic [`DILS_PAY_W-1:0] payload_t;
   typedef logic [`DILS_SEL_W-1:0] sel_t;

   typedef enum logic [1:0] {
      HOST_IDLE  = 2'b00,
      HOST_SHIFT = 2'b01,
      HOST_HOLD  = 2'b10,
      HOST_GAP   = 2'b11
   } host_state_t;

endpackage

// File: hdl/dils_link_if.sv
// three-wire serial link plus display inhibit, host to display device
// assumes: the host drives every wire; the device only listens
`timescale 1ns/10ps
`default_nettype none

interface dils_link_if;
   logic serial_clock_line;
   logic serial_data_in;
   logic serial_enable;
   logic display_inhibit_n;

   modport host (
      output serial_clock_line,
      output serial_data_in,
      output serial_enable,
      output display_inhibit_n
   );

   modport device (
      input serial_clock_line,
      input serial_data_in,
      input serial_enable,
      input display_inhibit_n
   );
endinterface

`default_nettype wire

// File: hdl/dils_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes: one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module dils_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic room;

   wire push = i_in_valid && room;
   wire pop = (count != '0) && i_out_ready;
   wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   // ready straight from a flop
   assign o_in_ready = room;
   assign o_out_valid = (count != '0);
   assign o_out_data = mem[rd_ptr];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         room <= 1'b1;
      end else begin
         wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
         rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
         count <= next_count;
         room <= (next_count != (AW+1)'(DEPTH));
      end
   end
endmodule

`default_nettype wire

// File: hdl/dils_device.sv
// display end: serial receiver on the link clock, display store and
// segment/common scan on I_CLK, blanking under the inhibit input
// assumes: the host keeps the link format and inter-frame spacing
`timescale 1ns/10ps
`default_nettype none
`include "dils_regs.svh"

module dils_device
   import dils_pkg::*;
(
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // link from the host
   dils_link_if.device LNK,
   // oscillator pin, external clock mode only
   input wire logic I_OSCILLATOR_PIN,
   // display drive
   output logic [`DILS_SEG_TOP:0] O_SEG,
   output logic [`DILS_ROWS-1:0] O_COM,
   output logic O_BLANK,
   output logic O_DUTY_QUARTER,
   output logic O_OSC_SOURCE_SELECT
);

   ////////////////////////////////////////////////////////////////////
   // link clock domain

   logic [`DILS_CNT_W-1:0] bit_count;
   logic [`DILS_FRAME_W-2:0] shift;
   frame_t frame_word;
   logic frame_done;

   wire link_shifting = (bit_count != `DILS_FRAME_BITS);
   wire link_last = (bit_count == `DILS_LAST_BIT);

   // counter cleared by the frame signal, since the link clock stops
   always_ff @(posedge LNK.serial_clock_line or negedge LNK.serial_enable) begin
      if (!LNK.serial_enable) begin
         bit_count <= '0;
      end else if (link_shifting) begin
         bit_count <= bit_count + 1'b1;
      end
   end

   always_ff @(posedge LNK.serial_clock_line) begin
      if (link_shifting) begin
         shift <= {shift[`DILS_FRAME_W-3:0], LNK.serial_data_in};
      end
   end

   // whole frame held until the next frame completes
   always_ff @(posedge LNK.serial_clock_line) begin
      if (link_last) begin
         frame_word <= {shift, LNK.serial_data_in};
      end
   end

   // level: frame complete, dropped when the frame signal falls
   always_ff @(posedge LNK.serial_clock_line or negedge LNK.serial_enable) begin
      if (!LNK.serial_enable) begin
         frame_done <= 1'b0;
      end else if (link_last) begin
         frame_done <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // crossings into I_CLK

   logic done_meta;
   logic done_sync;
   logic done_seen;
   logic inhibit_meta;
   logic inhibit_sync;
   logic osc_meta;
   logic osc_sync;
   logic osc_prev;

   always_ff @(posedge I_CLK) begin
      done_meta <= frame_done;
      done_sync <= done_meta;
      inhibit_meta <= LNK.display_inhibit_n;
      inhibit_sync <= inhibit_meta;
      osc_meta <= I_OSCILLATOR_PIN;
      osc_sync <= osc_meta;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         done_seen <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         done_seen <= done_sync;
         osc_prev <= osc_sync;
      end
   end

   // frame_word is stable here: host holds the frame signal after the last bit
   wire frame_take = done_sync && !done_seen;
   wire sel_t frame_sel = frame_word[`DILS_FRAME_W-1 -: `DILS_SEL_W];
   wire payload_t frame_pay = frame_word[`DILS_PAY_W-1:0];

   ////////////////////////////////////////////////////////////////////
   // display store and control settings

   payload_t disp_mem [`DILS_ROWS];
   logic duty_quarter;
   logic osc_source_select;

   wire is_part0 = (frame_sel == `DILS_SEL_PART0);
   wire is_part1 = (frame_sel == `DILS_SEL_PART1);
   wire is_part2 = (frame_sel == `DILS_SEL_PART2);
   wire is_part3 = (frame_sel == `DILS_SEL_PART3);
   wire is_ctrl = (frame_sel == `DILS_SEL_CTRL);
   wire is_part = is_part0 || is_part1 || is_part2 || is_part3;
   wire [`DILS_ROW_W-1:0] part_row = frame_sel[`DILS_ROW_W-1:0];
   // fourth part only exists in quarter duty
   wire part_ok = is_part && (duty_quarter || !is_part3);

   // store is never reset: contents undefined until loaded
   always_ff @(posedge I_CLK) begin
      if (frame_take && part_ok) begin
         disp_mem[part_row] <= frame_pay;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         duty_quarter <= 1'b0;
         osc_source_select <= 1'b0;
      end else if (frame_take && is_ctrl) begin
         duty_quarter <= frame_pay[`DILS_CTRL_DUTY_BIT];
         osc_source_select <= frame_pay[`DILS_CTRL_OSC_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // display timing source

   logic [`DILS_RC_DIV_W-1:0] rc_div;

   // internal oscillator modelled as a divider of I_CLK
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         rc_div <= '0;
      end else begin
         rc_div <= rc_div + 1'b1;
      end
   end

   wire rc_tick = (rc_div == `DILS_RC_DIV_LAST);
   wire ext_tick = osc_sync && !osc_prev;
   wire scan_tick = osc_source_select ? ext_tick : rc_tick;

   ////////////////////////////////////////////////////////////////////
   // common scan

   logic [`DILS_ROW_W-1:0] row;

   wire [`DILS_ROW_W-1:0] row_last =
      duty_quarter ? `DILS_ROW_LAST_QUARTER : `DILS_ROW_LAST_THIRD;
   wire [`DILS_ROW_W-1:0] next_row = (row >= row_last) ? '0 : row + 1'b1;

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         row <= '0;
      end else if (scan_tick) begin
         row <= next_row;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output drive with blanking

   wire blank = !inhibit_sync;
   wire payload_t row_data = disp_mem[row];
   // in quarter duty the top segment pin serves as the fourth common
   wire payload_t seg_view = duty_quarter ?
      {1'b0, row_data[`DILS_SEG_TOP-1:0]} : row_data;
   wire [`DILS_ROWS-1:0] com_view = `DILS_ROWS'(1) << row;
   wire payload_t next_seg = blank ? '0 : seg_view;
   wire [`DILS_ROWS-1:0] next_com = blank ? '0 : com_view;

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         O_SEG <= '0;
         O_COM <= '0;
         O_BLANK <= 1'b1;
         O_DUTY_QUARTER <= 1'b0;
         O_OSC_SOURCE_SELECT <= 1'b0;
      end else begin
         O_SEG <= next_seg;
         O_COM <= next_com;
         O_BLANK <= blank;
         O_DUTY_QUARTER <= duty_quarter;
         O_OSC_SOURCE_SELECT <= osc_source_select;
      end
   end

endmodule

`default_nettype wire

// File: hdl/dils_host.sv
// host end: queues frames, serialises them on a divided link clock,
// sequences the inhibit line and watches the whole-load time
// assumes: one clock I_CLK, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
`include "dils_regs.svh"

module dils_host
   import dils_pkg::*;
#(
   parameter int SLOW_CYC = `DILS_TRANSFER_MAX_NS / `DILS_CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // frame request
   input wire logic I_VALID,
   output logic O_READY,
   input wire logic [`DILS_SEL_W-1:0] I_SEL,
   input wire logic [`DILS_PAY_W-1:0] I_PAYLOAD,
   // display control
   input wire logic I_DISPLAY_ON,
   output logic O_BUSY,
   output logic O_SLOW,
   // link to the display
   dils_link_if.host LNK
);

   ////////////////////////////////////////////////////////////////////
   // frame queue

   frame_t q_data;
   logic q_valid;
   host_state_t state;

   wire q_pop = (state == HOST_IDLE);

   dils_fifo #(.WIDTH(`DILS_FRAME_W), .DEPTH(`DILS_FIFO_DEPTH), .AW(`DILS_FIFO_AW)) u_fifo (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_in_valid(I_VALID),
      .o_in_ready(O_READY),
      .i_in_data({I_SEL, I_PAYLOAD}),
      .o_out_valid(q_valid),
      .i_out_ready(q_pop),
      .o_out_data(q_data)
   );

   ////////////////////////////////////////////////////////////////////
   // serialiser

   frame_t word;
   logic [`DILS_CNT_W-1:0] bit_idx;
   logic [`DILS_HALF_W-1:0] half;
   logic [`DILS_WAIT_W-1:0] wait_cnt;
   logic sclk;
   logic sdata;
   logic sen;

   wire start = q_pop && q_valid;
   wire half_end = (half == `DILS_HALF_LAST);
   wire bit_end = half_end && sclk;
   wire last_bit = (bit_idx == `DILS_LAST_BIT);
   wire frame_t next_word = {word[`DILS_FRAME_W-2:0], 1'b0};

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         state <= HOST_IDLE;
         word <= '0;
         bit_idx <= '0;
         half <= '0;
         wait_cnt <= '0;
         sclk <= 1'b0;
         sdata <= 1'b0;
         sen <= 1'b0;
      end else begin
         case (state)
            HOST_IDLE: begin
               if (start) begin
                  state <= HOST_SHIFT;
                  word <= q_data;
                  sdata <= q_data[`DILS_FRAME_W-1];
                  bit_idx <= '0;
                  half <= '0;
                  sen <= 1'b1;
               end
            end
            HOST_SHIFT: begin
               // two I_CLK cycles per link clock half
               half <= half_end ? '0 : half + 1'b1;
               if (half_end) begin
                  sclk <= !sclk;
               end
               if (bit_end) begin
                  word <= next_word;
                  sdata <= next_word[`DILS_FRAME_W-1];
                  bit_idx <= bit_idx + 1'b1;
                  if (last_bit) begin
                     state <= HOST_HOLD;
                     wait_cnt <= '0;
                  end
               end
            end
            HOST_HOLD: begin
               wait_cnt <= wait_cnt + 1'b1;
               if (wait_cnt == `DILS_HOLD_LAST) begin
                  sen <= 1'b0;
                  state <= HOST_GAP;
                  wait_cnt <= '0;
               end
            end
            HOST_GAP: begin
               wait_cnt <= wait_cnt + 1'b1;
               if (wait_cnt == `DILS_GAP_LAST) begin
                  state <= HOST_IDLE;
               end
            end
            default: begin
               state <= HOST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // inhibit sequencing and load timer

   logic inhibit_n;
   logic timing;
   logic [`DILS_SLOW_W-1:0] slow_cnt;

   wire drained = (state == HOST_IDLE) && !q_valid && !I_VALID;
   // low from reset; raised only once every queued frame is out
   wire next_inhibit_n = I_DISPLAY_ON && (inhibit_n || drained);
   wire slow_hit = timing && (slow_cnt == `DILS_SLOW_W'(SLOW_CYC - 1));

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         inhibit_n <= 1'b0;
         timing <= 1'b0;
         slow_cnt <= '0;
         O_SLOW <= 1'b0;
         O_BUSY <= 1'b0;
      end else begin
         inhibit_n <= next_inhibit_n;
         timing <= !next_inhibit_n && (timing || start);
         slow_cnt <= (timing && !slow_hit) ? slow_cnt + 1'b1 : '0;
         O_SLOW <= O_SLOW || slow_hit;
         O_BUSY <= !drained;
      end
   end

   assign LNK.serial_clock_line = sclk;
   assign LNK.serial_data_in = sdata;
   assign LNK.serial_enable = sen;
   assign LNK.display_inhibit_n = inhibit_n;

endmodule

`default_nettype wire

// File: bench/dils_link_chk.sv
// link and display checker for the inhibit / load sequencer
// assumes: link wires come from host flops on I_CLK
`timescale 1ns/10ps
`default_nettype none
`include "dils_regs.svh"

module dils_link_chk (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // link
   input wire logic serial_clock_line,
   input wire logic serial_data_in,
   input wire logic serial_enable,
   input wire logic display_inhibit_n,
   // display drive
   input wire logic [`DILS_SEG_TOP:0] O_SEG,
   input wire logic [`DILS_ROWS-1:0] O_COM,
   input wire logic O_BLANK
);
   logic prev_clk;
   logic [`DILS_CNT_W-1:0] edges;
   wire logic clk_rise = serial_clock_line && !prev_clk;

   default clocking dflt @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   ////////////////////////////////////////////////////////////////
   // link clock rising edges within the current frame
   always_ff @(posedge I_CLK) begin
      prev_clk <= serial_clock_line;
      if (!I_RST_N || !serial_enable) begin
         edges <= '0;
      end else if (clk_rise) begin
         edges <= edges + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////
   AST_INH_LOW_AT_START: assert property (
      $rose(I_RST_N) |-> !display_inhibit_n)
      else $error("inhibit not low after reset");
   AST_BLANK_FOLLOWS_INHIBIT: assert property (
      !display_inhibit_n |-> ##3 O_BLANK)
      else $error("inhibit low without blanking");
   AST_BLANK_DRIVE: assert property (
      O_BLANK |-> (O_COM == '0) && (O_SEG == '0))
      else $error("outputs driven while blanked");
   AST_RESUME: assert property (
      display_inhibit_n [*3] |=> !O_BLANK && $onehot(O_COM))
      else $error("scan not resumed after inhibit release");
   AST_RELEASE_AFTER_LOAD: assert property (
      $rose(display_inhibit_n) |-> !serial_enable && !$past(serial_enable, 4))
      else $error("inhibit released during a transfer");
   AST_FRAME_LEN: assert property (
      $fell(serial_enable) |-> edges == `DILS_FRAME_BITS)
      else $error("frame clock count wrong");
   AST_CLK_IDLE_LOW: assert property (
      !serial_enable |-> !serial_clock_line)
      else $error("link clock moves outside a frame");
   AST_DATA_STEADY: assert property (
      serial_clock_line |-> $stable(serial_data_in))
      else $error("data changed while link clock high");
   AST_HALF_PERIOD: assert property (
      $rose(serial_clock_line) |-> serial_clock_line ##1 serial_clock_line ##1 !serial_clock_line)
      else $error("link clock half period wrong");
   AST_FRAME_GAP: assert property (
      $fell(serial_enable) |-> !serial_enable [*4])
      else $error("frames too close");

   COV_FRAME: cover property ($fell(serial_enable));
   COV_RELEASE: cover property ($rose(display_inhibit_n));
   COV_REBLANK: cover property ($fell(display_inhibit_n));
endmodule

`default_nettype wire

// File: bench/display_inhibit_load_sequencer_test.sv
// host and display ends joined over the link, driven from the host side
// assumes: design files and dils_regs.svh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "dils_regs.svh"
`define CHK(what, exp, got) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("FAIL %s expected %h seen %h", what, exp, got); \
   end \
end

module display_inhibit_load_sequencer_test
   import dils_pkg::*;
();
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic osc = 1'b0;
   logic osc_run = 1'b1;
   logic valid = 1'b0;
   logic disp_on = 1'b0;
   sel_t sel = '0;
   payload_t payload = '0;
   logic ready, busy, slow, blank, duty_q, osc_sel;
   logic [`DILS_SEG_TOP:0] seg;
   logic [`DILS_ROWS-1:0] com, held;
   payload_t exp_row [4];
   int fail_count = 0;
   int comparisons = 0;

   always #25 clk = ~clk;
   // offset keeps oscillator edges off I_CLK edges
   always #15 if (osc_run) osc <= #4 ~osc;

   ////////////////////////////////////////////////////////////////
   dils_link_if lnk ();
   dils_host #(.SLOW_CYC(4000)) u_dils_host (.I_CLK(clk), .I_RST_N(rst_n),
      .I_VALID(valid), .O_READY(ready), .I_SEL(sel), .I_PAYLOAD(payload),
      .I_DISPLAY_ON(disp_on), .O_BUSY(busy), .O_SLOW(slow), .LNK(lnk.host));
   dils_device u_dils_device (.I_CLK(clk), .I_RST_N(rst_n), .LNK(lnk.device),
      .I_OSCILLATOR_PIN(osc), .O_SEG(seg), .O_COM(com), .O_BLANK(blank),
      .O_DUTY_QUARTER(duty_q), .O_OSC_SOURCE_SELECT(osc_sel));
   dils_link_chk u_dils_link_chk (.I_CLK(clk), .I_RST_N(rst_n),
      .serial_clock_line(lnk.serial_clock_line), .serial_data_in(lnk.serial_data_in),
      .serial_enable(lnk.serial_enable), .display_inhibit_n(lnk.display_inhibit_n),
      .O_SEG(seg), .O_COM(com), .O_BLANK(blank));

   ////////////////////////////////////////////////////////////////
   task tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   function automatic payload_t pat(input int r);
      logic [135:0] w;
      w = {17{8'h3c ^ 8'(r * 8'h51)}};
      return w[`DILS_PAY_W-1:0];
   endfunction

   // valid stays up between back-to-back frames
   task send(input sel_t s, input payload_t p);
      int k;
      valid = 1'b1;
      sel = s;
      payload = p;
      for (k = 0; k < 5000 && ready !== 1'b1; k++) tick(1);
      tick(1);
   endtask

   task settle();
      int k;
      valid = 1'b0;
      for (k = 0; k < 5000 && busy !== 1'b0; k++) tick(1);
      `CHK("load drained", 1'b0, busy)
   endtask

   task load(input logic [1:0] ctrl, input int rows);
      int r;
      send(`DILS_SEL_CTRL, payload_t'(ctrl));
      for (r = 0; r < rows; r++) begin
         exp_row[r] = pat(r + ctrl);
         send(sel_t'(r), exp_row[r]);
      end
      settle();
   endtask

   task scan(input int n, input logic quarter, input logic dwell);
      int c, r, run, seen;
      logic [3:0] prev;
      run = 0;
      seen = 0;
      prev = com;
      for (c = 0; c < n; c++) begin
         tick(1);
         for (r = 0; r < 4; r++)
            if (com === 4'(4'h1 << r))
               `CHK("segments", quarter ? {1'b0, exp_row[r][127:0]} : exp_row[r], seg)
         if (!quarter)
            `CHK("fourth row idle", 1'b0, com[3])
         if (com !== prev) begin
            if (dwell && seen > 0)
               `CHK("row time", 32'h10, run)
            seen++;
            run = 1;
         end else begin
            run++;
         end
         prev = com;
      end
      `CHK("rows stepped", 1'b1, seen > 2)
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      tick(20000);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      tick(3);
      rst_n = 1'b1;
      `CHK("blank at start", 1'b1, blank)
      `CHK("com at start", 4'h0, com)
      load(2'b01, 4);
      `CHK("blank while loading", 1'b1, blank)
      `CHK("duty quarter", 1'b1, duty_q)
      `CHK("osc source int", 1'b0, osc_sel)
      disp_on = 1'b1;
      tick(6);
      `CHK("blank released", 1'b0, blank)
      `CHK("slow flag", 1'b0, slow)
      scan(100, 1'b1, 1'b1);
      load(2'b10, 3);
      `CHK("no reblank", 1'b0, blank)
      `CHK("osc source ext", 1'b1, osc_sel)
      osc_run = 1'b0;
      tick(5);
      held = com;
      tick(40);
      `CHK("row held without osc", held, com)
      osc_run = 1'b1;
      scan(60, 1'b0, 1'b0);
      disp_on = 1'b0;
      tick(6);
      `CHK("blank again", 1'b1, blank)
      `CHK("com blanked", 4'h0, com)
      rst_n = 1'b0;
      tick(3);
      rst_n = 1'b1;
      send(`DILS_SEL_CTRL, '0);
      settle();
      tick(4100);
      `CHK("slow load", 1'b1, slow)
      tally_and_finish();
   end
endmodule

`default_nettype wire
